// >>> bench/fdc_regfile_model.sv
`timescale 1ns/1ps
`default_nettype none
module fdc_regfile_model (
  input  wire logic        aclk,
  input  wire logic        wen_a,
  input  wire logic [6:0]  dest_a,
  input  wire logic [31:0] data_a,
  input  wire logic        wen_b,
  input  wire logic [6:0]  dest_b,
  input  wire logic [31:0] data_b,
  input  wire logic [6:0]  rd_idx,
  output logic [31:0]      rd_data
);
  logic [31:0] rf [128];
  // Entries start unlike any result, so a stray write cannot hide.
  initial begin
    for (int i = 0; i < 128; i++) begin
      rf[i] = 32'h5A5A5A00 | 32'(i);
    end
  end
  // Only pulsed write-backs land; a false guard must leave the entry alone.
  always @(posedge aclk) begin
    if (wen_a) rf[dest_a] <= data_a;
    if (wen_b) rf[dest_b] <= data_b;
  end
  assign rd_data = rf[rd_idx];
endmodule : fdc_regfile_model
`default_nettype wire

// >>> bench/float_divide_compare_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
module float_divide_compare_unit_tb;
  import fdc_pkg::*;
  typedef struct {logic [6:0] d; logic [31:0] v; int t;} fdc_exp_t;
  localparam logic [31:0] ONE = 32'h3F800000, THREE = 32'h40400000, DENORM = 32'h00400000;
  logic        aclk, aresetn, s2_valid, s2_guard_lsb, s2_ready, s3_valid, s3_guard_lsb;
  logic        div_wb_valid, cmp_wb_valid, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  s2_opcode, s3_opcode, s_axi_awaddr, s_axi_araddr;
  logic [6:0]  s2_dest, s3_dest, div_wb_dest, cmp_wb_dest, other_flag_updates, rd_idx;
  logic [31:0] s2_first_operand, s2_second_operand, s3_first_operand, s3_second_operand;
  logic [31:0] div_wb_data, cmp_wb_data, processor_status_word, s_axi_wdata, s_axi_rdata;
  logic [31:0] rf_q, rnd;
  int          errors, comparisons, cyc, c1, c2, i;
  fdc_exp_t    qd[$], qc[$];
  logic [33:0] qr[$];

  fdc_top dut (.aclk, .aresetn, .s2_valid, .s2_opcode, .s2_first_operand, .s2_second_operand,
    .s2_guard_lsb, .s2_dest, .s2_ready, .s3_valid, .s3_opcode, .s3_first_operand,
    .s3_second_operand, .s3_guard_lsb, .s3_dest, .other_flag_updates, .div_wb_valid,
    .div_wb_dest, .div_wb_data, .cmp_wb_valid, .cmp_wb_dest, .cmp_wb_data,
    .processor_status_word, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp);
  fdc_regfile_model rf (.aclk, .wen_a(div_wb_valid), .dest_a(div_wb_dest),
    .data_a(div_wb_data), .wen_b(cmp_wb_valid), .dest_b(cmp_wb_dest), .data_b(cmp_wb_data),
    .rd_idx, .rd_data(rf_q));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task summarize;
    if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task limit(input logic ok);
    if (!ok) chk("wait_bound", 32'h1, 32'h0);
    if (!ok) summarize();
  endtask : limit
  // The take edge is noted so latency is judged in cycles, not by waiting.
  task div(input logic [7:0] op, input logic [31:0] a, b, input logic g, input logic [6:0] d,
           input logic [31:0] e);
    logic r;
    @(posedge aclk);
    {s2_valid, s2_opcode, s2_guard_lsb, s2_dest} <= {1'b1, op, g, d};
    {s2_first_operand, s2_second_operand} <= {a, b};
    r = 1'b0;
    for (int n = 0; n < 60 && !r; n++) begin
      @(negedge aclk);
      r = s2_ready;
      @(posedge aclk);
    end
    limit(r);
    c1 = cyc;
    if (g) qd.push_back('{d, e, cyc + DIV_LATENCY});
    s2_valid <= 1'b0;
  endtask : div
  task cmp(input logic [7:0] op, input logic [31:0] a, b, input logic g, input logic [6:0] d,
           input logic [31:0] e);
    {s3_valid, s3_opcode, s3_guard_lsb, s3_dest} <= {1'b1, op, g, d};
    {s3_first_operand, s3_second_operand} <= {a, b};
    @(posedge aclk);
    if (g) qc.push_back('{d, e, cyc + 1});
  endtask : cmp
  task drain;
    for (int n = 0; n < 60 && qd.size() + qc.size() > 0; n++) @(posedge aclk);
    limit(qd.size() + qc.size() == 0);
  endtask : drain
  // Address and data are offered together and each is dropped once taken.
  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic ra, rw, rb;
    logic [1:0] br;
    @(posedge aclk);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_awaddr, s_axi_wdata} <= {3'b111, a, d};
    rb = 1'b0;
    for (int n = 0; n < 60 && !rb; n++) begin
      @(negedge aclk);
      {ra, rw, rb} = {s_axi_awready & s_axi_awvalid, s_axi_wready & s_axi_wvalid, s_axi_bvalid};
      br = s_axi_bresp;
      @(posedge aclk);
      if (ra) s_axi_awvalid <= 1'b0;
      if (rw) s_axi_wvalid <= 1'b0;
    end
    limit(rb);
    chk("bresp", 32'(RESP_OKAY), 32'(br));
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    logic ra, rv;
    @(posedge aclk);
    qr.push_back({r, e});
    {s_axi_arvalid, s_axi_rready, s_axi_araddr} <= {2'b11, a};
    rv = 1'b0;
    for (int n = 0; n < 60 && !rv; n++) begin
      @(negedge aclk);
      {ra, rv} = {s_axi_arready & s_axi_arvalid, s_axi_rvalid};
      if (rv && a == ADDR_STATUS) chk("status_word", e, processor_status_word);
      @(posedge aclk);
      if (ra) s_axi_arvalid <= 1'b0;
    end
    limit(rv);
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  task automatic mon(input string n, input logic v, input logic [6:0] d, input logic [31:0] x,
                     ref fdc_exp_t q[$]);
    fdc_exp_t e;
    if (v === 1'b1 && q.size() == 0) chk(n, 32'h0, 32'h1);
    else if (v === 1'b1) begin
      e = q.pop_front();
      chk(n, e.v, x);
      chk(n, 32'(e.t), 32'(cyc + 1));
      chk(n, 32'(e.d), 32'(d));
    end
  endtask : mon

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // Outputs are judged at the falling edge, clear of the launching edge.
  always @(negedge aclk) begin
    cyc <= cyc + 1;
    mon("div_wb", div_wb_valid, div_wb_dest, div_wb_data, qd);
    mon("cmp_wb", cmp_wb_valid, cmp_wb_dest, cmp_wb_data, qc);
    if (s_axi_rvalid === 1'b1) begin
      chk("rdata", qr[0][31:0], s_axi_rdata);
      chk("rresp", 32'(qr[0][33:32]), 32'(s_axi_rresp));
      void'(qr.pop_front());
    end
  end
  // Rounding first, then special values, guards and flag merging.
  initial begin
    {aresetn, s2_valid, s2_opcode, s2_guard_lsb, s2_dest, s3_valid, s3_opcode} = '0;
    {s3_guard_lsb, s3_dest, other_flag_updates, rd_idx, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {s2_first_operand, s2_second_operand, s3_first_operand, s3_second_operand} = '0;
    {s_axi_wdata, s_axi_wstrb, rnd} = {32'h0, 4'hF, 32'h1385};
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(ADDR_STATUS, 32'h0, RESP_OKAY);
    axi_rd(8'h08, 32'h0, RESP_SLVERR);
    axi_wr(ADDR_STATUS, 32'(RM_ZERO) << RMODE_LSB);
    div(OP_DIV, ONE, THREE, 1'b1, 7'h10, 32'h3EAAAAAA);
    c2 = c1;
    div(OP_DIV, 32'h00800000, THREE, 1'b1, 7'h11, 32'h0);
    chk("recovery", 32'(DIV_RECOVERY), 32'(c1 - c2));
    drain();
    axi_rd(ADDR_STATUS, 32'h146, RESP_OKAY);
    axi_wr(ADDR_STATUS, 32'h0);
    div(OP_DIV_FLAGS, THREE, DENORM, 1'b1, 7'h12, 32'h21);
    div(OP_DIV_FLAGS, 32'h7F7FFFFF, 32'h3E000000, 1'b0, 7'h13, 32'h0);
    div(OP_DIV_FLAGS, 32'h7F800000, 32'hFF800000, 1'b1, 7'h18, 32'h10);
    drain();
    axi_rd(ADDR_STATUS, 32'h0, RESP_OKAY);
    div(OP_DIV, 32'hC0400000, ONE, 1'b1, 7'h14, 32'hC0400000);
    div(OP_DIV, 32'h7F800000, 32'hFF800000, 1'b1, 7'h15, 32'hFFFFFFFF);
    div(OP_DIV, THREE, 32'h0, 1'b0, 7'h16, 32'h0);
    div(OP_DIV, THREE, DENORM, 1'b1, 7'h17, 32'h7F800000);
    drain();
    axi_rd(ADDR_STATUS, 32'h31, RESP_OKAY);
    axi_wr(ADDR_STATUS, 32'h0);
    cmp(OP_CMP_EQ, THREE, THREE, 1'b1, 7'h20, 32'h1);
    cmp(OP_CMP_EQ, THREE, 32'h0, 1'b1, 7'h21, 32'h0);
    cmp(OP_CMP_EQ_FLAGS, ONE, DENORM, 1'b1, 7'h22, 32'h20);
    cmp(OP_CMP_EQ, DENORM, 32'h0, 1'b0, 7'h19, 32'h0);
    s3_valid <= 1'b0;
    drain();
    axi_rd(ADDR_STATUS, 32'h0, RESP_OKAY);
    cmp(OP_CMP_EQ, ONE, DENORM, 1'b1, 7'h24, 32'h0);
    rnd = xs(rnd);
    {s3_valid, other_flag_updates} <= {1'b0, rnd[6:0]};
    @(posedge aclk);
    other_flag_updates <= 7'h0;
    drain();
    axi_rd(ADDR_STATUS, 32'h20 | 32'(rnd[6:0]), RESP_OKAY);
    for (i = 0; i < 3; i++) begin
      rd_idx = 7'h13 + 7'(i * 3);
      #1;
      chk("rf_guard_false", 32'h5A5A5A13 + 32'(i * 3), rf_q);
    end
    @(posedge aclk);
    for (i = 0; i < 4; i++) begin
      rnd = xs(rnd);
      cmp(OP_CMP_EQ, {rnd[31], 2'b01, rnd[28:0]}, {rnd[31], 2'b01, rnd[28:0]}, 1'b1,
          rnd[6:0], 32'h1);
      cmp(OP_CMP_EQ, {rnd[31], 2'b01, rnd[28:0]}, {~rnd[31], 2'b01, rnd[28:0]}, 1'b1,
          7'h30, 32'h0);
    end
    s3_valid <= 1'b0;
    drain();
    summarize();
  end
endmodule : float_divide_compare_unit_tb
`default_nettype wire

// >>> hdl/fdc_cmp_core.sv
`timescale 1ns/1ps
`default_nettype none
module fdc_cmp_core (
  input  wire logic [31:0]    first_operand,
  input  wire logic [31:0]    second_operand,
  output logic                equal,
  output fdc_pkg::fdc_flags_t flags
);
  import fdc_pkg::*;

  logic        a_den, b_den, a_nan, b_nan;
  logic [31:0] a_f, b_f;

  // Denormal operands are replaced by a signed zero before comparing.
  assign a_den = (first_operand[30:23] == 8'h00) && (first_operand[22:0] != 23'h0);
  assign b_den = (second_operand[30:23] == 8'h00) && (second_operand[22:0] != 23'h0);
  assign a_nan = (first_operand[30:23] == 8'hFF) && (first_operand[22:0] != 23'h0);
  assign b_nan = (second_operand[30:23] == 8'hFF) && (second_operand[22:0] != 23'h0);
  assign a_f   = a_den ? {first_operand[31], 31'h0} : first_operand;
  assign b_f   = b_den ? {second_operand[31], 31'h0} : second_operand;

  // Plus and minus zero compare equal; any NaN compares unequal.
  assign equal = !(a_nan || b_nan) && ((a_f == b_f) || ((a_f[30:0] == 31'h0) && (b_f[30:0] == 31'h0)));

  // Only a signalling NaN makes an equality test invalid.
  always_comb begin
    flags          = '0;
    flags[FLG_IN_FLUSH] = a_den | b_den;
    flags[FLG_BAD_OP] = (a_nan & ~first_operand[22]) | (b_nan & ~second_operand[22]);
  end

endmodule : fdc_cmp_core
`default_nettype wire

// >>> hdl/fdc_div_core.sv
`timescale 1ns/1ps
`default_nettype none
module fdc_div_core (
  input  wire logic [31:0]         dividend,
  input  wire logic [31:0]         divisor,
  input  wire fdc_pkg::fdc_rmode_t rmode,
  output fdc_pkg::fdc_flags_t      flags,
  output logic [31:0]              quotient
);
  import fdc_pkg::*;

  logic               a_den, b_den, a_zero, b_zero, a_inf, b_inf, a_nan, b_nan, sgn;
  logic [49:0]        num, den, q_full, rem;
  logic [26:0]        q;
  logic [23:0]        man;
  logic [24:0]        man_r;
  logic               rb, st, inc;
  logic signed [9:0]  e_base, e_norm, e_fin;

  // Classify operands; denormals count as zero once flushed.
  assign a_den  = (dividend[30:23] == 8'h00) && (dividend[22:0] != 23'h0);
  assign b_den  = (divisor[30:23] == 8'h00) && (divisor[22:0] != 23'h0);
  assign a_zero = dividend[30:23] == 8'h00;
  assign b_zero = divisor[30:23] == 8'h00;
  assign a_inf  = (dividend[30:23] == 8'hFF) && (dividend[22:0] == 23'h0);
  assign b_inf  = (divisor[30:23] == 8'hFF) && (divisor[22:0] == 23'h0);
  assign a_nan  = (dividend[30:23] == 8'hFF) && (dividend[22:0] != 23'h0);
  assign b_nan  = (divisor[30:23] == 8'hFF) && (divisor[22:0] != 23'h0);
  assign sgn    = dividend[31] ^ divisor[31];

  // Mantissa quotient with two guard positions; the remainder feeds the sticky bit.
  assign num    = {1'b1, dividend[22:0], 26'h0};
  assign den    = {26'h0, 1'b1, divisor[22:0]};
  assign q_full = num / den;
  assign rem    = num % den;
  assign q      = q_full[26:0];
  assign e_base = $signed({2'b00, dividend[30:23]}) - $signed({2'b00, divisor[30:23]}) + 10'sh07F;
  assign e_norm = q[26] ? e_base : e_base - 10'sh001;
  assign man    = q[26] ? q[26:3] : q[25:2];
  assign rb     = q[26] ? q[2] : q[1];
  assign st     = (q[26] ? (|q[1:0]) : q[0]) | (|rem);

  // The increment follows the rounding mode currently held in the status word.
  always_comb begin
    case (rmode)
      RM_NEAREST: inc = rb & (st | man[0]);
      RM_ZERO:    inc = 1'b0;
      RM_PLUS:    inc = ~sgn & (rb | st);
      RM_MINUS:   inc = sgn & (rb | st);
      default:    inc = 1'b0;
    endcase
  end

  assign man_r = {1'b0, man} + {24'h0, inc};
  assign e_fin = e_norm + $signed({9'h000, man_r[24]});

  // Specials first, then overflow and flushed underflow of the rounded quotient.
  always_comb begin
    flags          = '0;
    flags[FLG_IN_FLUSH] = a_den | b_den;
    quotient       = QNAN_ALL_ONES;
    if (a_nan || b_nan) begin
      flags[FLG_BAD_OP] = (a_nan & ~dividend[22]) | (b_nan & ~divisor[22]);
    end else if ((a_inf && b_inf) || (a_zero && b_zero)) begin
      flags[FLG_BAD_OP] = 1'b1;
    end else if (a_inf) begin
      quotient = {sgn, 8'hFF, 23'h0};
    end else if (b_zero) begin
      quotient       = POS_INFINITY;
      flags[FLG_DIV_ZERO] = 1'b1;
    end else if (a_zero || b_inf) begin
      quotient = {sgn, 31'h0};
    end else if (e_fin >= 10'sh0FF) begin
      flags[FLG_OVERFLOW] = 1'b1;
      flags[FLG_INEXACT] = 1'b1;
      if (rmode == RM_ZERO || (rmode == RM_PLUS && sgn) || (rmode == RM_MINUS && !sgn)) begin
        quotient = {sgn, 8'hFE, 23'h7FFFFF};
      end else begin
        quotient = {sgn, 8'hFF, 23'h0};
      end
    end else if (e_fin <= 10'sh000) begin
      quotient       = {sgn, 31'h0};
      flags[FLG_OUT_FLUSH] = 1'b1;
      flags[FLG_UNDERFLOW] = 1'b1;
      flags[FLG_INEXACT] = 1'b1;
    end else begin
      quotient       = {sgn, e_fin[7:0], man_r[24] ? 23'h0 : man_r[22:0]};
      flags[FLG_INEXACT] = rb | st;
    end
  end

endmodule : fdc_div_core
`default_nettype wire

// >>> hdl/fdc_pkg.sv
package fdc_pkg;

  // Operation codes seen on the issue slots.
  localparam logic [7:0] OP_DIV          = 8'h6C;
  localparam logic [7:0] OP_DIV_FLAGS    = 8'h6D;
  localparam logic [7:0] OP_CMP_EQ       = 8'h94;
  localparam logic [7:0] OP_CMP_EQ_FLAGS = 8'h95;

  // Pipeline timing in processor clock cycles.
  localparam int         DIV_LATENCY  = 17;
  localparam int         DIV_RECOVERY = 16;
  localparam logic [4:0] RECOV_LOAD   = 5'(DIV_RECOVERY - 1);

  // Flag vector positions, shared by the status word and the flags-only results.
  localparam int FLAG_W   = 7;
  localparam int FLG_OUT_FLUSH = 6;
  localparam int FLG_IN_FLUSH = 5;
  localparam int FLG_BAD_OP = 4;
  localparam int FLG_OVERFLOW = 3;
  localparam int FLG_UNDERFLOW = 2;
  localparam int FLG_INEXACT = 1;
  localparam int FLG_DIV_ZERO = 0;
  localparam int RMODE_LSB = 8;

  // Special single-precision patterns.
  localparam logic [31:0] QNAN_ALL_ONES = 32'hFFFFFFFF;
  localparam logic [31:0] POS_INFINITY  = 32'h7F800000;

  // Rounding modes held in the status word.
  localparam logic [1:0] RM_NEAREST = 2'h0;
  localparam logic [1:0] RM_ZERO    = 2'h1;
  localparam logic [1:0] RM_PLUS    = 2'h2;
  localparam logic [1:0] RM_MINUS   = 2'h3;

  // Register map and bus answers.
  localparam int         AXI_ADDR_W     = 8;
  localparam logic [7:0] ADDR_STATUS    = 8'h00;
  localparam logic [7:0] ADDR_DIV_STATE = 8'h04;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;

  // Destination register index width.
  localparam int DEST_W = 7;

  typedef logic [FLAG_W-1:0] fdc_flags_t;
  typedef logic [1:0]        fdc_rmode_t;

endpackage : fdc_pkg

// >>> hdl/fdc_top.sv
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module fdc_top (
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic                         s2_valid,
  input  wire logic [7:0]                   s2_opcode,
  input  wire logic [31:0]                  s2_first_operand,
  input  wire logic [31:0]                  s2_second_operand,
  input  wire logic                         s2_guard_lsb,
  input  wire logic [fdc_pkg::DEST_W-1:0]   s2_dest,
  output logic                              s2_ready,
  input  wire logic                         s3_valid,
  input  wire logic [7:0]                   s3_opcode,
  input  wire logic [31:0]                  s3_first_operand,
  input  wire logic [31:0]                  s3_second_operand,
  input  wire logic                         s3_guard_lsb,
  input  wire logic [fdc_pkg::DEST_W-1:0]   s3_dest,
  input  wire fdc_pkg::fdc_flags_t          other_flag_updates,
  output logic                              div_wb_valid,
  output logic [fdc_pkg::DEST_W-1:0]        div_wb_dest,
  output logic [31:0]                       div_wb_data,
  output logic                              cmp_wb_valid,
  output logic [fdc_pkg::DEST_W-1:0]        cmp_wb_dest,
  output logic [31:0]                       cmp_wb_data,
  output logic [31:0]                       processor_status_word,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [fdc_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  output logic [1:0]                        s_axi_bresp,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  input  wire logic [fdc_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp
);
  import fdc_pkg::*;

  typedef struct packed {
    logic              valid;
    logic              flags_only;
    logic [DEST_W-1:0] dest;
    logic [31:0]       data;
    fdc_flags_t        flags;
  } fdc_slot_t;

  typedef struct packed {
    fdc_slot_t [DIV_LATENCY-2:0] pipe; // The write-back register is stage 17.
    logic [4:0]                  recov_cnt;
    logic                        div_wb_valid;
    logic                        div_wb_fo;
    fdc_flags_t                  div_wb_flags;
    logic [DEST_W-1:0]           div_wb_dest;
    logic [31:0]                 div_wb_data;
    logic                        cmp_wb_valid;
    logic [DEST_W-1:0]           cmp_wb_dest;
    logic [31:0]                 cmp_wb_data;
    fdc_flags_t                  status_flags;
    fdc_rmode_t                  rmode;
    logic                        aw_have;
    logic [AXI_ADDR_W-1:0]       aw_addr;
    logic                        w_have;
    logic [31:0]                 w_data;
    logic [3:0]                  w_strb;
    logic                        bvalid;
    logic [1:0]                  bresp;
    logic                        rvalid;
    logic [31:0]                 rdata;
    logic [1:0]                  rresp;
  } fdc_state_t;

  fdc_state_t  state_reg;
  fdc_state_t  state_next;
  logic [31:0] div_quotient;
  fdc_flags_t  div_flags;
  logic        cmp_equal;
  fdc_flags_t  cmp_flags;
  logic        s2_take;
  logic        s3_take;
  logic        wr_fire;
  logic        status_wr;
  fdc_flags_t  div_upd;
  fdc_flags_t  cmp_upd;
  fdc_slot_t   last;

  // The divide is computed at issue and then only delayed, so the core holds no state.
  fdc_div_core u_div (
    .dividend (s2_first_operand),
    .divisor  (s2_second_operand),
    .rmode    (state_reg.rmode),
    .flags    (div_flags),
    .quotient (div_quotient)
  );

  fdc_cmp_core u_cmp (
    .first_operand  (s3_first_operand),
    .second_operand (s3_second_operand),
    .equal          (cmp_equal),
    .flags          (cmp_flags)
  );

  // Issue acceptance; unknown opcodes on a slot are ignored.
  assign s2_ready = state_reg.recov_cnt == 5'h00;
  assign s2_take  = s2_valid && s2_ready && (s2_opcode == OP_DIV || s2_opcode == OP_DIV_FLAGS);
  assign s3_take  = s3_valid && (s3_opcode == OP_CMP_EQ || s3_opcode == OP_CMP_EQ_FLAGS);
  assign last     = state_reg.pipe[DIV_LATENCY-2];

  // Flag contributions that land in the status word at the coming edge.
  assign div_upd   = (last.valid && !last.flags_only) ? last.flags : '0;
  assign cmp_upd   = (s3_take && s3_guard_lsb && s3_opcode == OP_CMP_EQ) ? cmp_flags : '0;
  assign wr_fire   = state_reg.aw_have && state_reg.w_have && !state_reg.bvalid;
  assign status_wr = wr_fire && state_reg.aw_addr == ADDR_STATUS && state_reg.w_strb[0];

  // Next-state logic for pipeline, status word and bus slave.
  always_comb begin
    state_next         = state_reg;
    state_next.pipe[0] = '0;
    for (int i = 1; i < DIV_LATENCY - 1; i++) begin
      state_next.pipe[i] = state_reg.pipe[i-1];
    end
    if (s2_take) begin
      state_next.pipe[0].valid      = s2_guard_lsb;
      state_next.pipe[0].flags_only = s2_opcode == OP_DIV_FLAGS;
      state_next.pipe[0].dest       = s2_dest;
      state_next.pipe[0].data       = div_quotient;
      state_next.pipe[0].flags      = div_flags;
      state_next.recov_cnt          = RECOV_LOAD;
    end else if (state_reg.recov_cnt != 5'h00) begin
      state_next.recov_cnt = state_reg.recov_cnt - 5'h01;
    end
    // The last stage retires into the write-back registers one edge later.
    state_next.div_wb_valid = last.valid;
    state_next.div_wb_fo    = last.flags_only;
    state_next.div_wb_flags = last.flags;
    state_next.div_wb_dest  = last.dest;
    state_next.div_wb_data  = last.flags_only ? {25'h0, last.flags} : last.data;
    state_next.cmp_wb_valid = s3_take && s3_guard_lsb;
    state_next.cmp_wb_dest  = s3_dest;
    state_next.cmp_wb_data  = (s3_opcode == OP_CMP_EQ_FLAGS) ? {25'h0, cmp_flags} : {31'h0, cmp_equal};
    // A status write loads the flags, but same-edge updates are still ORed on top.
    state_next.status_flags = (status_wr ? state_reg.w_data[FLAG_W-1:0] : state_reg.status_flags)
                              | div_upd | cmp_upd | other_flag_updates;
    if (wr_fire && state_reg.aw_addr == ADDR_STATUS && state_reg.w_strb[1]) begin
      state_next.rmode = state_reg.w_data[RMODE_LSB +: 2];
    end
    // Write channel: address and data are taken in either order.
    if (s_axi_awvalid && s_axi_awready) begin
      state_next.aw_have = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      state_next.w_have = 1'b1;
      state_next.w_data = s_axi_wdata;
      state_next.w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      state_next.aw_have = 1'b0;
      state_next.w_have  = 1'b0;
      state_next.bvalid  = 1'b1;
      state_next.bresp   = (state_reg.aw_addr == ADDR_STATUS || state_reg.aw_addr == ADDR_DIV_STATE)
                           ? RESP_OKAY : RESP_SLVERR;
    end else if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end
    // Read channel: one outstanding read, answered the cycle after the address.
    if (s_axi_arvalid && s_axi_arready) begin
      state_next.rvalid = 1'b1;
      state_next.rresp  = RESP_OKAY;
      case (s_axi_araddr)
        ADDR_STATUS:    state_next.rdata = {22'h0, state_reg.rmode, 1'b0, state_reg.status_flags};
        ADDR_DIV_STATE: state_next.rdata = {23'h0, last.valid, 3'h0, state_reg.recov_cnt};
        default: begin
          state_next.rdata = 32'h0;
          state_next.rresp = RESP_SLVERR;
        end
      endcase
    end else if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end
  end

  // Single synchronous state register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state register.
  assign div_wb_valid          = state_reg.div_wb_valid;
  assign div_wb_dest           = state_reg.div_wb_dest;
  assign div_wb_data           = state_reg.div_wb_data;
  assign cmp_wb_valid          = state_reg.cmp_wb_valid;
  assign cmp_wb_dest           = state_reg.cmp_wb_dest;
  assign cmp_wb_data           = state_reg.cmp_wb_data;
  assign processor_status_word = {22'h0, state_reg.rmode, 1'b0, state_reg.status_flags};
  assign s_axi_awready         = !state_reg.aw_have;
  assign s_axi_wready          = !state_reg.w_have;
  assign s_axi_bvalid          = state_reg.bvalid;
  assign s_axi_bresp           = state_reg.bresp;
  assign s_axi_arready         = !state_reg.rvalid;
  assign s_axi_rvalid          = state_reg.rvalid;
  assign s_axi_rdata           = state_reg.rdata;
  assign s_axi_rresp           = state_reg.rresp;

  // Checks on the block's own timing and flag behaviour.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  div_latency_a: assert property (
    s2_take && s2_guard_lsb |-> ##17 div_wb_valid)
    else $error("Divide result not written 17 cycles after issue.");

  div_recovery_a: assert property (
    s2_take |-> ##15 !s2_ready ##1 s2_ready)
    else $error("Divide recovery interval is not 16 cycles.");

  guard_no_write_a: assert property (
    s2_take && !s2_guard_lsb |-> ##17 !div_wb_valid)
    else $error("Divide with false guard wrote its destination.");

  cmp_latency_a: assert property (
    s3_take && s3_guard_lsb && s3_opcode == OP_CMP_EQ |=> cmp_wb_valid && cmp_wb_data[31:1] == 31'h0)
    else $error("Compare-equal result late or not 0 or 1.");

  flags_sticky_a: assert property (
    !status_wr |=> (state_reg.status_flags & $past(state_reg.status_flags))
                   == $past(state_reg.status_flags))
    else $error("Status flag cleared without a status write.");

  flags_same_cycle_a: assert property (
    div_wb_valid && !state_reg.div_wb_fo |->
      (state_reg.status_flags & state_reg.div_wb_flags) == state_reg.div_wb_flags)
    else $error("Divide flags not in status word at write-back.");

  flags_only_upper_a: assert property (
    (div_wb_valid && state_reg.div_wb_fo) || (cmp_wb_valid && $past(s3_opcode == OP_CMP_EQ_FLAGS))
      |-> (!state_reg.div_wb_fo || div_wb_data[31:7] == 25'h0)
          && (!$past(s3_opcode == OP_CMP_EQ_FLAGS) || cmp_wb_data[31:7] == 25'h0))
    else $error("Flags-only result has bits above bit 6.");

  guard_no_flags_a: assert property (
    s3_take && !s3_guard_lsb && div_upd == '0 && other_flag_updates == '0 && !status_wr
      |=> $stable(state_reg.status_flags))
    else $error("Compare with false guard changed status flags.");

  div_zero_inf_a: assert property (
    s2_take && s2_guard_lsb && s2_opcode == OP_DIV && s2_second_operand[30:23] == 8'h00
      && s2_first_operand[30:23] != 8'h00 && s2_first_operand[30:23] != 8'hFF
      |-> ##17 div_wb_data == POS_INFINITY)
    else $error("Finite over zero did not give plus infinity.");

  div_inf_nan_a: assert property (
    s2_take && s2_guard_lsb && s2_opcode == OP_DIV_FLAGS
      && s2_first_operand[30:0] == 31'h7F800000 && s2_second_operand[30:0] == 31'h7F800000
      |-> ##17 div_wb_data[FLG_BAD_OP])
    else $error("Infinity over infinity did not raise invalid.");

  cov_div_c:     cover property (s2_take && s2_guard_lsb && s2_opcode == OP_DIV ##17 div_wb_valid);
  cov_divflg_c:  cover property (div_wb_valid && state_reg.div_wb_fo);
  cov_cmp_eq_c:  cover property (cmp_wb_valid && cmp_wb_data == 32'h00000001);
  cov_wr_race_c: cover property (status_wr && (div_upd != '0 || cmp_upd != '0));

endmodule : fdc_top
`default_nettype wire
